// ### logic/sicp_port.sv
// serial interconnect port connection-service adapter, top level
// assumes port layer issues one request per cycle and keeps its own buffers in a memory
// reached through the memory port; send read data stands in the rd_en cycle
`timescale 1ns/100ps

// Overview of operation
// - connect or listen opens connection immediately
// - connect or listen sends nothing on link
// - connected indication with id on accept
// - second open refused with port in use
// - send size counts encoded characters exactly
// - receive writes no more than size
// - received uses buffer of last receive
// - received count equals characters written
// - accepted send characters still sent after close
// - link characters after close may drop
// - undelivered characters still delivered after close
// - closed raised only after all delivered
// - second receive refused as outstanding
// - no received after closed until connected
module sicp_port
  import sicp_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  input  wire sicp_pkg::sicp_req_t    req,        // service request
  output sicp_pkg::sicp_rsp_t         rsp,        // service response
  output sicp_pkg::sicp_ind_t         ind,        // service indications
  output sicp_pkg::sicp_mem_t         mem,        // buffer memory access
  input  wire logic [SICP_CHAR_W-1:0] memRdData,  // send buffer read data
  output logic                        txValid,    // character to the physical link
  output logic [SICP_CHAR_W-1:0]      txData,
  input  wire logic                   txReady,
  input  wire logic                   rxValid,    // character from the physical link
  input  wire logic [SICP_CHAR_W-1:0] rxData,
  output logic                        rxReady
);
  import sicp_pkg::*;

  // ------------------------------------------------------------
  // connection state
  // ------------------------------------------------------------
  // idle: no connection; open: link taken;
  // closing: both sides drain, then back to idle
  typedef enum {ST_IDLE, ST_OPEN, ST_CLOSING} sicp_conn_t;
  sicp_conn_t connSt_r;                            // connection state
  sicp_conn_t connSt_nxt;

  // send engine
  logic                   txBusy_r;                // send in progress
  logic [SICP_ADDR_W-1:0] txAddr_r;                // next read address
  logic [SICP_SIZE_W-1:0] txLeft_r;                // characters not yet fetched
  logic                   txPend_r;                // fetched character waiting for link
  logic                   rdWait_r;                // read issued last cycle
  logic [SICP_SIZE_W-1:0] txSize_r;                // size of the send in flight
  logic [SICP_SIZE_W-1:0] txSent_r;                // characters the link took

  // receive engine
  logic                   rxArmed_r;               // receive outstanding
  logic [SICP_ADDR_W-1:0] rxBase_r;                // buffer of last receive
  logic [SICP_SIZE_W-1:0] rxMax_r;                 // size limit of last receive
  logic [SICP_SIZE_W-1:0] rxCnt_r;                 // characters written so far
  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  wire isOpenReq  = req.valid && (req.code == SICP_REQ_CONNECT || req.code == SICP_REQ_LISTEN);
  wire isSendReq  = req.valid && (req.code == SICP_REQ_SEND);
  wire isRecvReq  = req.valid && (req.code == SICP_REQ_RECEIVE);
  wire isCloseReq = req.valid && (req.code == SICP_REQ_CLOSE);
  wire connIdOk   = (req.conn == SICP_CONN_ID);
  wire isOpen     = (connSt_r == ST_OPEN);
  wire isClosing  = (connSt_r == ST_CLOSING);

  // accepted requests
  wire openOk  = isOpenReq && (connSt_r == ST_IDLE);
  wire sendOk  = isSendReq && isOpen && connIdOk && !txBusy_r;
  wire recvOk  = isRecvReq && (isOpen || isClosing) && connIdOk && !rxArmed_r
                 && (req.buf_size != SICP_SIZE_ZERO);
  wire closeOk = isCloseReq && isOpen && connIdOk;

  // status selection; for data requests a foreign id
  // is reported before any state-based refusal
  sicp_rsp_e_t rspCode;
  always_comb begin
    rspCode = SICP_RSP_GOOD;
    if (isOpenReq && !openOk) rspCode = SICP_RSP_PORT_USE;
    else if ((isSendReq || isRecvReq || isCloseReq) && !connIdOk) rspCode = SICP_RSP_INV_CONN;
    else if (isSendReq && !isOpen) rspCode = SICP_RSP_INV_CONN;
    else if (isSendReq && txBusy_r) rspCode = SICP_RSP_NO_RES;
    else if (isRecvReq && !(isOpen || isClosing)) rspCode = SICP_RSP_INV_CONN;
    else if (isRecvReq && rxArmed_r) rspCode = SICP_RSP_RX_PEND;
    else if (isRecvReq && req.buf_size == SICP_SIZE_ZERO) rspCode = SICP_RSP_INV_BUF;
    else if (isCloseReq && !isOpen) rspCode = SICP_RSP_INV_CONN;
  end

  // ------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------
  logic                   holdEmpty;
  logic [SICP_CHAR_W-1:0] holdData;
  logic                   holdReady;
  wire rxFlush  = (connSt_r == ST_IDLE);
  // take only under the registered ready, so far side and queue
  // agree; ready drops with close, later characters stay out
  wire rxTake   = rxValid && rxReady;
  // one write per cycle, never past the receive size
  wire rxWrite  = rxArmed_r && !holdEmpty && (rxCnt_r != rxMax_r);
  wire [SICP_SIZE_W-1:0] rxCntInc = rxCnt_r + SICP_SIZE_ONE;
  // deliver when buffer full, or queue drained with something written
  wire rxDone   = rxArmed_r && (rxCnt_r != SICP_SIZE_ZERO)
                  && ((rxCnt_r == rxMax_r) || holdEmpty);
  // in closing, nothing more can arrive, so an empty queue ends it
  wire allDelivered = holdEmpty && !(rxArmed_r && rxCnt_r != SICP_SIZE_ZERO);
  wire closeDone    = isClosing && allDelivered && !txBusy_r;

  // holds link characters until a receive is armed
  sicp_rx_hold u_hold (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .flush     (rxFlush),
    .pushValid (rxTake),
    .pushData  (rxData),
    .pushReady (holdReady),
    .popReq    (rxWrite),
    .popData   (holdData),
    .holdEmpty (holdEmpty)
  );

  // ------------------------------------------------------------
  // connection state machine
  // ------------------------------------------------------------
  // next state; close cannot finish while the send
  // or the receive side still holds characters
  always_comb begin
    connSt_nxt = connSt_r;
    case (connSt_r)
      ST_IDLE:    if (openOk) connSt_nxt = ST_OPEN;
      ST_OPEN:    if (closeOk) connSt_nxt = ST_CLOSING;
      ST_CLOSING: if (closeDone) connSt_nxt = ST_IDLE;
      default:    connSt_nxt = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) connSt_r <= ST_IDLE;
    else         connSt_r <= connSt_nxt;
  end

  // ------------------------------------------------------------
  // send engine: fetch one character, hold it until link takes it
  // ------------------------------------------------------------
  wire txFire  = txPend_r && txReady;
  wire fetchGo = txBusy_r && (txLeft_r != SICP_SIZE_ZERO) && !rdWait_r && (!txPend_r);
  wire txLast  = txFire && (txLeft_r == SICP_SIZE_ZERO);

  // one send held at a time; a second is refused, not queued
  // a zero-length send completes without touching the link
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      txBusy_r <= 1'b0;
      txAddr_r <= '0;
      txLeft_r <= '0;
    end else if (sendOk) begin
      txBusy_r <= (req.buf_size != SICP_SIZE_ZERO);
      txAddr_r <= req.buf_addr;
      txLeft_r <= req.buf_size;
    end else begin
      if (fetchGo) begin
        txAddr_r <= txAddr_r + SICP_SIZE_ONE;
        txLeft_r <= txLeft_r - SICP_SIZE_ONE;
      end
      if (txLast) txBusy_r <= 1'b0;
    end
  end

  // capture of the fetch answer and hold for the link
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdWait_r <= 1'b0;
      txPend_r <= 1'b0;
      txData   <= '0;
    end else begin
      rdWait_r <= fetchGo;
      if (rdWait_r) begin
        txPend_r <= 1'b1;
        txData   <= memRdData;
      end else if (txFire) begin
        txPend_r <= 1'b0;
      end
    end
  end
  assign txValid = txPend_r;

  // tally of link takes, kept apart from the fetch count for the checks
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      txSize_r <= '0;
      txSent_r <= '0;
    end else if (sendOk) begin
      txSize_r <= req.buf_size;
      txSent_r <= '0;
    end else if (txFire) begin
      txSent_r <= txSent_r + SICP_SIZE_ONE;
    end
  end

  // ------------------------------------------------------------
  // receive engine
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rxArmed_r <= 1'b0;
      rxBase_r  <= '0;
      rxMax_r   <= '0;
      rxCnt_r   <= '0;
    // a receive that meets the end of close is dropped with it
    end else if (recvOk && !closeDone) begin
      rxArmed_r <= 1'b1;
      rxBase_r  <= req.buf_addr;
      rxMax_r   <= req.buf_size;
      rxCnt_r   <= '0;
    end else if (rxDone || closeDone || connSt_r == ST_IDLE) begin
      rxArmed_r <= 1'b0;
      rxCnt_r   <= '0;
    end else if (rxWrite) begin
      rxCnt_r   <= rxCntInc;
    end
  end

  // ------------------------------------------------------------
  // registered outputs: every pin from a flop, so no far-side
  // combinational path can loop back into the request
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rsp     <= '0;
      ind     <= '0;
      mem     <= '0;
      rxReady <= 1'b0;
    end else begin
      rsp.valid     <= req.valid;
      rsp.status    <= rspCode;
      ind.connected <= openOk;
      ind.received  <= rxDone && !closeDone;
      ind.closed    <= closeDone;
      ind.conn      <= SICP_CONN_ID;
      ind.buf_addr  <= rxBase_r;
      ind.count     <= rxCnt_r;
      mem.rd_en     <= fetchGo;
      mem.rd_addr   <= txAddr_r;
      mem.wr_en     <= rxWrite;
      mem.wr_addr   <= rxBase_r + rxCnt_r;
      mem.wr_data   <= holdData;
      // open next cycle and two slots free
      rxReady       <= holdReady && (connSt_nxt == ST_OPEN);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // all checks rest during reset; the bench itself
  // looks at the outputs settling to zero there
  open_busy_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (isOpenReq && connSt_r != ST_IDLE) |=> (rsp.valid && rsp.status == SICP_RSP_PORT_USE))
    else $error("open while connected not refused");
  open_ind_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    openOk |=> (ind.connected && connSt_r == ST_OPEN && ind.conn == SICP_CONN_ID))
    else $error("open without connected indication");
  open_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (openOk && !txBusy_r) |=> ##1 !txValid)
    else $error("link driven by open");
  rx_pend_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (isRecvReq && rxArmed_r && connIdOk) |=> (rsp.status == SICP_RSP_RX_PEND))
    else $error("second receive accepted");
  rx_limit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rxArmed_r |-> (rxCnt_r <= rxMax_r))
    else $error("receive overran buffer");
  rx_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ind.received |-> (ind.count != SICP_SIZE_ZERO && ind.count <= rxMax_r && ind.buf_addr == rxBase_r))
    else $error("received count wrong");
  closed_drain_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    closeDone |-> (holdEmpty && !txBusy_r && !txPend_r))
    else $error("closed before drain");
  closed_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ind.closed |=> (!ind.received)[*2])
    else $error("received after closed");
  bad_id_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (isSendReq && !connIdOk) |=> (rsp.status == SICP_RSP_INV_CONN))
    else $error("foreign id accepted");
  tx_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    txLast |-> (txSent_r + SICP_SIZE_ONE == txSize_r))
    else $error("send length wrong");

  // main scenarios: open, delivery, drained close, full send
  open_c:  cover property (@(posedge clk_sys) disable iff (sys_rst) openOk);
  recv_c:  cover property (@(posedge clk_sys) disable iff (sys_rst) ind.received);
  close_c: cover property (@(posedge clk_sys) disable iff (sys_rst) isClosing ##[1:50] ind.closed);
  send_c:  cover property (@(posedge clk_sys) disable iff (sys_rst) txLast);
endmodule

// ### logic/sicp_pkg.sv
// package for the serial interconnect port connection-service adapter
// assumes one clock domain; buffers are addressed by a base pointer from the port layer
package sicp_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int SICP_CHAR_W = 8;                       // encoded character width
  localparam int SICP_ADDR_W = 16;                      // buffer address width
  localparam int SICP_SIZE_W = 16;                      // buffer size / count width
  localparam int SICP_CONN_W = 4;                       // connection identifier width
  localparam int SICP_RXQ_D  = 16;                      // receive holding depth
  localparam int SICP_RXQ_AW = 4;                       // receive holding pointer width
  // ------------------------------------------------------------
  // constants
  // ------------------------------------------------------------
  localparam logic [SICP_CONN_W-1:0] SICP_CONN_ID  = 4'h1;   // the single connection id
  localparam logic [SICP_SIZE_W-1:0] SICP_SIZE_ZERO = 16'h0000;
  localparam logic [SICP_SIZE_W-1:0] SICP_SIZE_ONE  = 16'h0001;
  localparam logic [SICP_RXQ_AW:0]   SICP_CNT_ONE   = 5'h01;
  localparam logic [SICP_RXQ_AW:0]   SICP_CNT_FULL  = 5'h10;

  // service request codes
  typedef enum logic [2:0] {
    SICP_REQ_CONNECT = 3'h0,
    SICP_REQ_LISTEN  = 3'h1,
    SICP_REQ_SEND    = 3'h2,
    SICP_REQ_RECEIVE = 3'h3,
    SICP_REQ_CLOSE   = 3'h4
  } sicp_req_e_t;

  // service response codes
  typedef enum logic [2:0] {
    SICP_RSP_GOOD       = 3'h0,
    SICP_RSP_INV_CONN   = 3'h1,
    SICP_RSP_PORT_USE   = 3'h2,
    SICP_RSP_RX_PEND    = 3'h3,
    SICP_RSP_NO_RES     = 3'h4,
    SICP_RSP_INV_BUF    = 3'h5
  } sicp_rsp_e_t;

  // request from the port layer
  typedef struct packed {
    logic                   valid;
    sicp_req_e_t            code;
    logic [SICP_CONN_W-1:0] conn;
    logic [SICP_ADDR_W-1:0] buf_addr;
    logic [SICP_SIZE_W-1:0] buf_size;
  } sicp_req_t;

  // response to the port layer
  typedef struct packed {
    logic        valid;
    sicp_rsp_e_t status;
  } sicp_rsp_t;

  // indication to the port layer
  typedef struct packed {
    logic                   connected;
    logic                   received;
    logic                   closed;
    logic [SICP_CONN_W-1:0] conn;
    logic [SICP_ADDR_W-1:0] buf_addr;
    logic [SICP_SIZE_W-1:0] count;
  } sicp_ind_t;

  // buffer memory access (reads for send, writes for receive)
  typedef struct packed {
    logic                   rd_en;
    logic [SICP_ADDR_W-1:0] rd_addr;
    logic                   wr_en;
    logic [SICP_ADDR_W-1:0] wr_addr;
    logic [SICP_CHAR_W-1:0] wr_data;
  } sicp_mem_t;
endpackage

// ### logic/sicp_rx_hold.sv
// receive character holding queue for the serial interconnect port
// assumes a synchronous flush and one push/pop port each
`timescale 1ns/100ps
module sicp_rx_hold
  import sicp_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  input  wire logic                   flush,      // drop all held characters
  input  wire logic                   pushValid,  // character from the link
  input  wire logic [SICP_CHAR_W-1:0] pushData,
  output logic                        pushReady,  // two slots free
  input  wire logic                   popReq,     // take head character
  output logic [SICP_CHAR_W-1:0]      popData,
  output logic                        holdEmpty
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [SICP_CHAR_W-1:0] mem [SICP_RXQ_D];     // character array
  logic [SICP_RXQ_AW-1:0] wrPtr_r;              // write pointer
  logic [SICP_RXQ_AW-1:0] rdPtr_r;              // read pointer
  logic [SICP_RXQ_AW:0]   cnt_r;                // fill count

  wire notFull = (cnt_r != SICP_CNT_FULL);
  wire doPush = pushValid && notFull && !flush;
  wire doPop  = popReq && !holdEmpty && !flush;

  // ready wants two free slots: the caller registers it, so one
  // more push may land after it was formed
  assign pushReady = (cnt_r < (SICP_CNT_FULL - SICP_CNT_ONE));
  assign holdEmpty = (cnt_r == '0);
  assign popData   = mem[rdPtr_r];

  // pointer and count update; flush wins so nothing stale survives
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r   <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r   <= '0;
    end else begin
      if (doPush) wrPtr_r <= wrPtr_r + 1'b1;
      if (doPop)  rdPtr_r <= rdPtr_r + 1'b1;
      if (doPush && !doPop) cnt_r <= cnt_r + SICP_CNT_ONE;
      else if (doPop && !doPush) cnt_r <= cnt_r - SICP_CNT_ONE;
    end
  end

  // data array has no reset
  always_ff @(posedge clk_sys) begin
    if (doPush) mem[wrPtr_r] <= pushData;
  end
endmodule

// ### tb/sicp_link_model.sv
// partner model: port layer buffer memory, link transmit sink, link receive source
// assumes one clock; the bench preloads memArr, pushes rxQ and steers txStall
`timescale 1ns/100ps
module sicp_link_model;
endmodule
module sicp_link_far (
  input  wire logic                            clk_sys,
  input  wire logic                            txStall,    // hold the sink off
  input  wire sicp_pkg::sicp_mem_t             mem,        // buffer access from the port
  output logic [sicp_pkg::SICP_CHAR_W-1:0]     memRdData,  // fetch answer
  input  wire logic                            txValid,
  input  wire logic [sicp_pkg::SICP_CHAR_W-1:0] txData,
  output logic                                 txReady,
  output logic                                 rxValid,
  output logic [sicp_pkg::SICP_CHAR_W-1:0]     rxData,
  input  wire logic                            rxReady
);
  import sicp_pkg::*;
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [SICP_CHAR_W-1:0] memArr [0:65535];  // buffers of the port layer
  logic [SICP_CHAR_W-1:0] txLog [$];         // characters seen on the link
  logic [SICP_CHAR_W-1:0] rxQ [$];           // characters still to offer
  logic                   rxTook = 1'b0;     // offer taken at the last edge
  // read data stands only while rd_en does; the inverse shows
  // otherwise so a capture in the wrong cycle is caught
  assign memRdData = mem.rd_en ? memArr[mem.rd_addr] : ~memArr[mem.rd_addr];
  initial begin
    txReady = 1'b0;
    rxValid = 1'b0;
    rxData = 8'h00;
  end
  // ----------------------------------------
  // clocked side
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (mem.wr_en) begin
      memArr[mem.wr_addr] <= mem.wr_data;
    end
    if (txValid && txReady) begin
      txLog.push_back(txData);  // each encoded character counted once
    end
    rxTook <= rxValid && rxReady;
  end
  // offers change only off the sampling edge and hold until taken
  always @(negedge clk_sys) begin
    txReady <= !txStall;
    if (rxTook) begin
      void'(rxQ.pop_front());
    end
    if (rxQ.size() > 0) begin
      rxValid <= 1'b1;
      rxData <= rxQ[0];
    end else begin
      rxValid <= 1'b0;
      rxData <= ~rxData;  // released line keeps no old value
    end
  end
endmodule

// ### tb/sicp_port_test.sv
// self-checking bench for the serial interconnect port adapter
// assumes sicp_link_far stands in for buffer memory and the physical link
`timescale 1ns/100ps
module sicp_port_test;
  import sicp_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                   clk_sys;
  logic                   sys_rst;
  logic                   txStall;             // sink stall control
  sicp_req_t              req;
  sicp_rsp_t              rsp;
  sicp_ind_t              ind;
  sicp_mem_t              mem;
  logic [SICP_CHAR_W-1:0] memRdData;
  logic [SICP_CHAR_W-1:0] txData;
  logic [SICP_CHAR_W-1:0] rxData;
  logic                   txValid;
  logic                   txReady;
  logic                   rxValid;
  logic                   rxReady;
  int                     errTotal = 0;
  int                     checkCount = 0;
  int                     closedCount = 0;     // closed pulses seen
  logic                   linkOpen = 1'b0;     // between connected and closed
  logic [15:0]            rcvAddr [$];         // received indications
  logic [15:0]            rcvCnt [$];
  logic [7:0]             expQ [$];            // link characters in offer order
  typedef struct packed {
    sicp_req_e_t code;
    logic [3:0]  conn;
    logic [15:0] addr;
    logic [15:0] size;
    sicp_rsp_e_t st;
    logic        opened;
  } sicp_row_t;
  // ordinary requests from idle: refusals, one open, then a single armed receive
  sicp_row_t rows [11] = '{
    '{SICP_REQ_SEND, 4'h1, 16'h0000, 16'h0001, SICP_RSP_INV_CONN, 1'b0},
    '{SICP_REQ_RECEIVE, 4'h1, 16'h0100, 16'h0004, SICP_RSP_INV_CONN, 1'b0},
    '{SICP_REQ_CLOSE, 4'h1, 16'h0000, 16'h0000, SICP_RSP_INV_CONN, 1'b0},
    '{SICP_REQ_CONNECT, 4'h0, 16'h0000, 16'h0000, SICP_RSP_GOOD, 1'b1},
    '{SICP_REQ_LISTEN, 4'h0, 16'h0000, 16'h0000, SICP_RSP_PORT_USE, 1'b0},
    '{SICP_REQ_CONNECT, 4'h0, 16'h0000, 16'h0000, SICP_RSP_PORT_USE, 1'b0},
    '{SICP_REQ_SEND, 4'h2, 16'h0200, 16'h0001, SICP_RSP_INV_CONN, 1'b0},
    '{SICP_REQ_CLOSE, 4'h3, 16'h0000, 16'h0000, SICP_RSP_INV_CONN, 1'b0},
    '{SICP_REQ_RECEIVE, 4'h1, 16'h0100, 16'h0000, SICP_RSP_INV_BUF, 1'b0},
    '{SICP_REQ_RECEIVE, 4'h1, 16'h0100, 16'h0004, SICP_RSP_GOOD, 1'b0},
    '{SICP_REQ_RECEIVE, 4'h1, 16'h0180, 16'h0004, SICP_RSP_RX_PEND, 1'b0}};
  // ----------------------------------------
  // instances
  // ----------------------------------------
  sicp_port sicp_port_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .rsp(rsp), .ind(ind),
    .mem(mem), .memRdData(memRdData), .txValid(txValid), .txData(txData), .txReady(txReady),
    .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady));
  sicp_link_far sicp_link_far_inst (.clk_sys(clk_sys), .txStall(txStall), .mem(mem),
    .memRdData(memRdData), .txValid(txValid), .txData(txData), .txReady(txReady),
    .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady));
  sicp_link_model sicp_link_model_inst ();
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmpVal(input logic [63:0] exp, input logic [63:0] got);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic cmpStatus(input sicp_rsp_e_t exp, input logic valid, input sicp_rsp_e_t got);
    cmpVal({60'h0, 1'b1, exp}, {60'h0, valid, got});
  endtask
  // one request pulse; answer and connected pulse both stand in the next cycle
  task automatic doReq(input sicp_req_e_t code, input logic [3:0] conn, input logic [15:0] addr,
                       input logic [15:0] size, input sicp_rsp_e_t st, input logic opened);
    @(negedge clk_sys);
    req = '{1'b1, code, conn, addr, size};
    @(negedge clk_sys);
    cmpStatus(st, rsp.valid, rsp.status);
    cmpVal(64'({opened, SICP_CONN_ID}), 64'({ind.connected, opened ? ind.conn : SICP_CONN_ID}));
    req.valid = 1'b0;
  endtask
  task automatic pushRx(input int n, input logic [7:0] first);
    for (int i = 0; i < n; i++) begin
      sicp_link_far_inst.rxQ.push_back(first + 8'(i));
      expQ.push_back(first + 8'(i));
    end
  endtask
  // a delivery lands whole in the named buffer and stops short of the sentinel
  task automatic waitRecv(input logic [15:0] addr, input int n);
    for (int i = 0; i < 200 && rcvAddr.size() == 0; i++) begin
      @(negedge clk_sys);
    end
    repeat (3) @(negedge clk_sys);
    cmpVal(64'h1, 64'(rcvAddr.size()));
    if (rcvAddr.size() > 0) begin
      cmpVal(64'(addr), 64'(rcvAddr.pop_front()));
      cmpVal(64'(n), 64'(rcvCnt.pop_front()));
      for (int i = 0; i < n; i++) begin
        cmpVal(64'(expQ.pop_front()), 64'(sicp_link_far_inst.memArr[addr + 16'(i)]));
      end
      cmpVal(64'h55, 64'(sicp_link_far_inst.memArr[addr + 16'(n)]));
    end
  endtask
  task automatic waitClosed(input int n);
    for (int i = 0; i < 300 && closedCount < n; i++) begin
      @(negedge clk_sys);
    end
    cmpVal(64'(n), 64'(closedCount));
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, monitor, watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // indications are looked at once they have settled
  always @(negedge clk_sys) begin
    if (sys_rst) begin
      linkOpen = 1'b0;
    end else begin
      if (ind.received) begin
        cmpVal(64'h1, 64'(linkOpen));
        rcvAddr.push_back(ind.buf_addr);
        rcvCnt.push_back(ind.count);
      end
      if (ind.closed) begin
        closedCount++;
        linkOpen = 1'b0;
      end
      if (ind.connected) begin
        linkOpen = 1'b1;
      end
    end
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    errTotal++;
    summarize();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    req = '0;
    txStall = 1'b0;
    foreach (sicp_link_far_inst.memArr[i]) sicp_link_far_inst.memArr[i] = 8'h55;
    for (int i = 0; i < 5; i++) sicp_link_far_inst.memArr[16'h0200 + 16'(i)] = 8'hA0 + 8'(i);
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      doReq(rows[i].code, rows[i].conn, rows[i].addr, rows[i].size, rows[i].st, rows[i].opened);
    end
    cmpVal(64'h0, 64'(sicp_link_far_inst.txLog.size()));
    // more characters than the armed receive can hold
    pushRx(6, 8'hC0);
    waitRecv(16'h0100, 4);
    doReq(SICP_REQ_RECEIVE, 4'h1, 16'h0300, 16'h0008, SICP_RSP_GOOD, 1'b0);
    waitRecv(16'h0300, 2);
    // close with characters still held: delivery must go on before closed
    pushRx(3, 8'hD0);
    repeat (10) @(negedge clk_sys);
    doReq(SICP_REQ_CLOSE, 4'h1, 16'h0000, 16'h0000, SICP_RSP_GOOD, 1'b0);
    repeat (20) @(negedge clk_sys);
    cmpVal(64'h0, 64'(closedCount));
    doReq(SICP_REQ_RECEIVE, 4'h1, 16'h0400, 16'h0008, SICP_RSP_GOOD, 1'b0);
    waitRecv(16'h0400, 3);
    waitClosed(1);
    // close while a send is stalled on the link
    doReq(SICP_REQ_LISTEN, 4'h9, 16'h0000, 16'h0000, SICP_RSP_GOOD, 1'b1);
    txStall = 1'b1;
    doReq(SICP_REQ_SEND, 4'h1, 16'h0200, 16'h0005, SICP_RSP_GOOD, 1'b0);
    doReq(SICP_REQ_SEND, 4'h1, 16'h0200, 16'h0005, SICP_RSP_NO_RES, 1'b0);
    doReq(SICP_REQ_CLOSE, 4'h1, 16'h0000, 16'h0000, SICP_RSP_GOOD, 1'b0);
    doReq(SICP_REQ_SEND, 4'h1, 16'h0200, 16'h0001, SICP_RSP_INV_CONN, 1'b0);
    repeat (20) @(negedge clk_sys);
    cmpVal(64'h1, 64'(closedCount));
    txStall = 1'b0;
    waitClosed(2);
    cmpVal(64'h5, 64'(sicp_link_far_inst.txLog.size()));
    for (int i = 0; i < 5; i++) begin
      cmpVal(64'(8'hA0 + 8'(i)), 64'(sicp_link_far_inst.txLog[i]));
    end
    // reset in mid-connection drops it and quiets every output
    doReq(SICP_REQ_CONNECT, 4'h0, 16'h0000, 16'h0000, SICP_RSP_GOOD, 1'b1);
    sys_rst = 1'b1;
    @(negedge clk_sys);
    cmpVal(64'h0, 64'({rsp.valid, ind.connected, ind.received, ind.closed, mem.rd_en, mem.wr_en, txValid}));
    sys_rst = 1'b0;
    doReq(SICP_REQ_LISTEN, 4'h0, 16'h0000, 16'h0000, SICP_RSP_GOOD, 1'b1);
    repeat (5) @(negedge clk_sys);
    summarize();
  end
endmodule
